// ### bbp_core.sv
// Operation
// [RULE_01] Set, clear or invert any addressed bit in one cycle.
// [RULE_02] One-byte set, clear, invert act on the carry.
// [RULE_03] Eight-bit bit address selects one of 256 bits.
// [RULE_04] Bit to carry in one cycle; carry to bit in two.
// [RULE_05] AND/OR carry with addressed bit, result into carry.
// [RULE_06] Inverted-operand AND/OR; the source bit never changes.
// [RULE_07] Jump on carry set, or on carry clear.
// [RULE_08] Jump on addressed bit set, or clear; three bytes.
// [RULE_09] Jump-and-clear branches on set bit and clears it.
// [RULE_10] Conditional jumps are relative and always take two cycles.
// [RULE_11] Signed displacement added to PC past the instruction.
// [RULE_12] Zero displacement lands on the next instruction.
// [RULE_13] Short jump uses the same relative displacement.
// [RULE_14] Accumulator and B bits are individually addressable.
// [RULE_15] Carry lives in the status word; byte writes change it.
// [RULE_16] All status word bits, parity included, are testable.
// [RULE_17] Port pins are testable; output latches invertible in one cycle.
// [RULE_18] Timer run flags start/stop timers and read back state.
// [RULE_19] Timer overflow flags testable and clearable by bit ops.
// [RULE_20] Rotates and arithmetic also update the carry.
// [RULE_21] Addresses below 80H map to RAM bytes 20H to 2FH.
// [RULE_22] Addresses 80H up map to registers: upper five bits, bit index.
// [RULE_23] Bit writes are read-modify-write of the whole byte.
`timescale 1ns/1ps
`default_nettype none
module bbp_core
    import bbp_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    // Wishbone slave
    input  wire logic        wb_cyc,
    input  wire logic        wb_stb,
    input  wire logic        wb_we,
    input  wire logic [11:0] wb_adr,
    input  wire logic [3:0]  wb_sel,
    input  wire logic [31:0] wb_dat_w,
    output logic      [31:0] wb_dat_r,
    output logic             wb_ack,
    // Port pins
    input  wire logic [31:0] port_pin,
    output logic      [31:0] port_out,
    // Timers
    input  wire logic [1:0]  tmr_ovf,
    output logic      [1:0]  timer_run,
    // Carry from rotates and arithmetic
    input  wire logic        alu_cy_we,
    input  wire logic        alu_cy,
    // Core status
    output logic      [15:0] pc_out,
    output logic             busy
);
    import bbp_pkg::*;

    bbp_state_t  state_q;
    bbp_cmd_t    cmd_q;
    logic [15:0] pc_q;
    logic        taken_q;
    logic        ack_q;
    logic [31:0] rdat_q;
    logic [31:0] pin_s1_q;
    logic [31:0] pin_s2_q;
    logic [7:0]  ram_q [16];
    logic [7:0]  acc_q;
    logic [7:0]  b_q;
    logic [6:1]  psw_q;
    logic        cy_q;
    logic [7:0]  tcon_q;
    logic [31:0] port_q;

    // Pins sample the pin value, read-modify-write uses the latch
    function automatic logic [7:0] rd_byte(input logic [7:0] a, input logic pins);
        logic [7:0] v;
        v = 8'h00;
        // [RULE_21] RAM bit block
        if (a[7:4] == BBP_RAM_HI)
            v = ram_q[a[3:0]];
        // [RULE_17] Pins or latches
        for (int i = 0; i < 4; i++)
        begin
            if (a == BBP_PORT_ADR[i])
                v = pins ? pin_s2_q[8*i +: 8] : port_q[8*i +: 8];
        end
        // [RULE_14] Accumulator and B bytes
        if (a == BBP_ACC_ADR)
            v = acc_q;
        if (a == BBP_B_ADR)
            v = b_q;
        // [RULE_16] Parity tracks the accumulator
        if (a == BBP_PSW_ADR)
            v = {cy_q, psw_q, ^acc_q};
        if (a == BBP_TCON_ADR)
            v = tcon_q;
        return v;
    endfunction : rd_byte

    // [RULE_22] Register bit space
    function automatic logic [7:0] byte_of(input logic [7:0] bit_adr);
        return bit_adr[7] ? {bit_adr[7:3], 3'h0} : {BBP_RAM_HI, bit_adr[6:3]};
    endfunction : byte_of

    // Execution operand
    // [RULE_03] Full 8-bit bit address
    wire logic [7:0]  x_adr      = byte_of(cmd_q.bit_adr);
    wire logic [2:0]  x_pos      = cmd_q.bit_adr[2:0];
    wire logic [7:0]  x_mask     = 8'h01 << x_pos;
    wire logic [7:0]  x_test     = rd_byte(x_adr, 1'b1);
    wire logic [7:0]  x_latch    = rd_byte(x_adr, 1'b0);
    wire logic        test_bit   = x_test[x_pos];
    wire logic        latch_bit  = x_latch[x_pos];

    logic        op_bit_we;
    logic        op_bit_val;
    logic        op_cy_we;
    logic        op_cy_val;
    logic        op_two;
    logic        op_cond;
    logic [15:0] op_len;

    always_comb
    begin
        op_bit_we  = 1'b0;
        op_bit_val = 1'b0;
        op_cy_we   = 1'b0;
        op_cy_val  = cy_q;
        op_two     = 1'b0;
        op_cond    = 1'b0;
        op_len     = BBP_LEN2;
        case (cmd_q.op)
            // [RULE_02] Carry forms
            OP_SET_C:    begin op_cy_we = 1'b1; op_cy_val = 1'b1;  op_len = BBP_LEN1; end
            OP_CLR_C:    begin op_cy_we = 1'b1; op_cy_val = 1'b0;  op_len = BBP_LEN1; end
            OP_INV_C:    begin op_cy_we = 1'b1; op_cy_val = ~cy_q; op_len = BBP_LEN1; end
            // [RULE_01] Constant load or invert
            OP_SET_BIT:  begin op_bit_we = 1'b1; op_bit_val = 1'b1; end
            OP_CLR_BIT:  begin op_bit_we = 1'b1; op_bit_val = 1'b0; end
            OP_INV_BIT:  begin op_bit_we = 1'b1; op_bit_val = ~latch_bit; end
            // [RULE_04] Transfers
            OP_BIT_TO_C: begin op_cy_we = 1'b1; op_cy_val = test_bit; end
            OP_C_TO_BIT: begin op_bit_we = 1'b1; op_bit_val = cy_q; op_two = 1'b1; end
            // [RULE_05] [RULE_06] Logic into carry only
            OP_AND_BIT:  begin op_cy_we = 1'b1; op_cy_val = cy_q & test_bit; end
            OP_AND_NBIT: begin op_cy_we = 1'b1; op_cy_val = cy_q & ~test_bit; end
            OP_OR_BIT:   begin op_cy_we = 1'b1; op_cy_val = cy_q | test_bit; end
            OP_OR_NBIT:  begin op_cy_we = 1'b1; op_cy_val = cy_q | ~test_bit; end
            // [RULE_07] Carry tests
            OP_JC:       begin op_two = 1'b1; op_cond = cy_q; end
            OP_JNC:      begin op_two = 1'b1; op_cond = ~cy_q; end
            // [RULE_08] Bit tests
            OP_JB:       begin op_two = 1'b1; op_cond = test_bit;  op_len = BBP_LEN3; end
            OP_JNB:      begin op_two = 1'b1; op_cond = ~test_bit; op_len = BBP_LEN3; end
            // [RULE_09] Clear goes in the second cycle
            OP_JBC:      begin op_two = 1'b1; op_cond = test_bit;  op_len = BBP_LEN3;
                               op_bit_we = 1'b1; end
            // [RULE_13] Unconditional relative
            OP_SHORT_RELATIVE_JUMP_OP:     begin op_two = 1'b1; op_cond = 1'b1; end
            default:     begin op_len = BBP_LEN1; end
        endcase
    end

    wire logic in_c1   = (state_q == ST_CYC1);
    wire logic in_c2   = (state_q == ST_CYC2);
    wire logic jbc_ok  = (cmd_q.op != OP_JBC) | taken_q;
    wire logic x_bit_we = op_bit_we & ((in_c1 & ~op_two) | (in_c2 & op_two & jbc_ok));
    wire logic x_cy_we  = op_cy_we & in_c1;
    // [RULE_23] Merge one bit into the latched byte
    wire logic [7:0] x_wdat = (x_latch & ~x_mask) | (op_bit_val ? x_mask : 8'h00);

    // [RULE_11] Target from advanced PC and signed byte
    wire logic [15:0] pc_next = 16'(pc_q + op_len);
    wire logic [15:0] pc_jump = 16'(pc_next + {{8{cmd_q.rel[7]}}, cmd_q.rel});

    // Bus decode
    wire logic hit_cmd  = (wb_adr[11:2] == BBP_CMD_OFS[11:2]);
    wire logic hit_pc   = (wb_adr[11:2] == BBP_PC_OFS[11:2]);
    wire logic hit_stat = (wb_adr[11:2] == BBP_STAT_OFS[11:2]);
    wire logic hit_win  = (wb_adr[11:10] == BBP_WIN_TAG);
    wire logic [7:0] win_adr = wb_adr[9:2];
    // Requests wait while an instruction runs, so bus and core never collide
    wire logic ack_d    = wb_cyc & wb_stb & ~ack_q & (state_q == ST_IDLE);
    wire logic bus_wr   = ack_q & wb_we & wb_sel[0];
    wire logic win_we   = bus_wr & hit_win;

    wire logic       wr_en = x_bit_we | win_we;
    wire logic [7:0] wr_a  = x_bit_we ? x_adr : win_adr;
    wire logic [7:0] wr_d  = x_bit_we ? x_wdat : wb_dat_w[7:0];

    wire logic [31:0] rd_mux =
        hit_cmd  ? {11'h0, cmd_q} :
        hit_pc   ? {16'h0000, pc_q} :
        hit_stat ? {29'h0, taken_q, cy_q, busy} :
        hit_win  ? {24'h000000, rd_byte(win_adr, 1'b1)} : 32'h00000000;

    // [RULE_19] Overflow set wins over a same-cycle clear
    wire logic [7:0] tcon_wr  = (wr_en && wr_a == BBP_TCON_ADR) ? wr_d : tcon_q;
    wire logic [7:0] tcon_set = (8'(tmr_ovf[1]) << BBP_TF1_POS) | (8'(tmr_ovf[0]) << BBP_TF0_POS);

    always_ff @(posedge sys_clk)
    begin
        pin_s1_q <= port_pin;
        pin_s2_q <= pin_s1_q;
    end

    // Byte storage
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < 16; i++)
                ram_q[i] <= BBP_BYTE_RST;
            acc_q  <= BBP_BYTE_RST;
            b_q    <= BBP_BYTE_RST;
            psw_q  <= BBP_BYTE_RST[6:1];
            tcon_q <= BBP_BYTE_RST;
            port_q <= BBP_PORT_RST;
        end
        else
        begin
            if (wr_en && wr_a[7:4] == BBP_RAM_HI)
                ram_q[wr_a[3:0]] <= wr_d;
            if (wr_en && wr_a == BBP_ACC_ADR)
                acc_q <= wr_d;
            if (wr_en && wr_a == BBP_B_ADR)
                b_q <= wr_d;
            if (wr_en && wr_a == BBP_PSW_ADR)
                psw_q <= wr_d[6:1];
            // [RULE_18] Run flags held here drive the timers
            tcon_q <= tcon_wr | tcon_set;
            for (int i = 0; i < 4; i++)
            begin
                if (wr_en && wr_a == BBP_PORT_ADR[i])
                    port_q[8*i +: 8] <= wr_d;
            end
        end
    end

    // Carry: instruction, then status byte write, then ALU
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
            cy_q <= 1'b0;
        else if (x_cy_we)
            cy_q <= op_cy_val;
        // [RULE_15] Byte write to the status word
        else if (wr_en && wr_a == BBP_PSW_ADR)
            cy_q <= wr_d[BBP_CY_POS];
        // [RULE_20] Rotate and arithmetic side effect
        else if (alu_cy_we)
            cy_q <= alu_cy;
    end

    // Sequencer
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            state_q <= ST_IDLE;
            cmd_q   <= '0;
            pc_q    <= BBP_PC_RST;
            taken_q <= 1'b0;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    if (bus_wr && hit_cmd)
                    begin
                        cmd_q   <= bbp_cmd_t'(wb_dat_w[20:0]);
                        state_q <= ST_CYC1;
                    end
                    if (bus_wr && hit_pc)
                        pc_q <= wb_dat_w[15:0];
                end
                ST_CYC1:
                begin
                    // [RULE_10] Jumps always take the second cycle
                    if (op_two)
                    begin
                        taken_q <= op_cond;
                        state_q <= ST_CYC2;
                    end
                    else
                    begin
                        pc_q    <= pc_next;
                        state_q <= ST_IDLE;
                    end
                end
                ST_CYC2:
                begin
                    // [RULE_12] Zero offset gives pc_next
                    pc_q    <= taken_q ? pc_jump : pc_next;
                    state_q <= ST_IDLE;
                end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            ack_q  <= 1'b0;
            rdat_q <= '0;
        end
        else
        begin
            ack_q  <= ack_d;
            rdat_q <= ack_d ? rd_mux : rdat_q;
        end
    end

    assign wb_ack    = ack_q;
    assign wb_dat_r  = rdat_q;
    assign port_out  = port_q;
    assign timer_run = {tcon_q[BBP_TR1_POS], tcon_q[BBP_TR0_POS]};
    assign pc_out    = pc_q;
    assign busy      = (state_q != ST_IDLE);
endmodule : bbp_core
`default_nettype wire

// ### bbp_core_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module bbp_core_asserts (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        nrst,
    // Wishbone
    input wire logic        wb_cyc,
    input wire logic        wb_stb,
    input wire logic        wb_we,
    input wire logic [11:0] wb_adr,
    input wire logic [3:0]  wb_sel,
    input wire logic [31:0] wb_dat_w,
    input wire logic [31:0] wb_dat_r,
    input wire logic        wb_ack,
    // Far side
    input wire logic [31:0] port_pin,
    input wire logic [31:0] port_out,
    input wire logic [1:0]  tmr_ovf,
    input wire logic [1:0]  timer_run,
    input wire logic        alu_cy_we,
    input wire logic        alu_cy,
    // Status
    input wire logic [15:0] pc_out,
    input wire logic        busy
);
    import bbp_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    wire logic       wr_ack = wb_ack && wb_we && wb_sel[0];
    wire logic       cmd_go = wr_ack && wb_adr == BBP_CMD_OFS;
    wire logic [4:0] op     = wb_dat_w[20:16];

    AST_ONE_CYCLE: assert property
        (cmd_go && (op < 5'd7 || op inside {[5'd8:5'd11]}) |=> busy ##1 !busy)
        else $error("one-cycle op busy length wrong");
    AST_TWO_CYCLE: assert property
        (cmd_go && (op == 5'd7 || op inside {[5'd12:5'd17]}) |=> busy [*2] ##1 !busy)
        else $error("two-cycle op busy length wrong");
    AST_ACK_TAKEN: assert property
        (wb_ack |-> $past(wb_cyc && wb_stb && !busy) ##1 !wb_ack)
        else $error("ack without idle request or too long");
    AST_PC_MOVES: assert property
        ($changed(pc_out) |-> ($past(busy) && !busy) || $past(wr_ack && wb_adr == BBP_PC_OFS))
        else $error("pc changed outside instruction end");
    AST_SHORT_JUMP: assert property
        (cmd_go && op == 5'd17 |-> ##3 pc_out == $past(pc_out, 3) + 16'h0002
            + {{8{$past(wb_dat_w[15], 3)}}, $past(wb_dat_w[15:8], 3)})
        else $error("short jump target wrong");
    AST_PORT_HOLD: assert property
        ($changed(port_out) |-> $past(busy) || $past(wr_ack))
        else $error("port latch changed without cause");
    AST_RUN_HOLD: assert property
        ($changed(timer_run) |-> $past(busy) || $past(wr_ack))
        else $error("timer run changed without cause");
    AST_WIN_UPPER: assert property
        (wb_ack && !wb_we && wb_adr[11:10] == BBP_WIN_TAG |-> wb_dat_r[31:8] == 24'h000000)
        else $error("byte window upper bits not zero");
    AST_RESET: assert property (disable iff (1'b0)
        !nrst |=> port_out == BBP_PORT_RST && pc_out == BBP_PC_RST && !busy && !wb_ack && timer_run == 2'h0)
        else $error("reset values wrong");
endmodule : bbp_core_asserts

bind bbp_core bbp_core_asserts bbp_core_asserts_i (.sys_clk, .nrst, .wb_cyc, .wb_stb, .wb_we, .wb_adr,
    .wb_sel, .wb_dat_w, .wb_dat_r, .wb_ack, .port_pin, .port_out, .tmr_ovf, .timer_run, .alu_cy_we,
    .alu_cy, .pc_out, .busy);
`default_nettype wire

// ### bbp_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module bbp_core_tb;
    import bbp_pkg::*;
    typedef struct packed {
        bbp_op_t     op;
        logic [7:0]  ba;
        logic [7:0]  rel;
        logic [7:0]  ini;
        logic        cy;
        logic [7:0]  eb;
        logic        ec;
        logic [15:0] epc;
    } bbp_row_t;
    logic        sys_clk = 1'b0, nrst = 1'b0, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack, busy;
    logic        alu_cy_we = 1'b0, alu_cy = 1'b0;
    logic [11:0] wb_adr = 12'h000;
    logic [3:0]  wb_sel = 4'h0;
    logic [31:0] wb_dat_w = 32'h0, ext_low = 32'h0, wb_dat_r, port_pin, port_out, q;
    logic [1:0]  tmr_ovf, timer_run;
    logic [15:0] pc_out;
    int          bad_count = 0, checks_done = 0, cycles = 0;
    bbp_row_t    rows [21] = '{
        '{OP_SET_C, 8'h00, 8'h00, 8'h00, 1'h0, 8'h00, 1'h1, 16'h0101},
        '{OP_CLR_C, 8'h00, 8'h00, 8'h00, 1'h1, 8'h00, 1'h0, 16'h0101},
        '{OP_INV_C, 8'h00, 8'h00, 8'h00, 1'h0, 8'h00, 1'h1, 16'h0101},
        '{OP_SET_BIT, 8'h7f, 8'h00, 8'h00, 1'h0, 8'h80, 1'h0, 16'h0102},
        '{OP_CLR_BIT, 8'h08, 8'h00, 8'hff, 1'h0, 8'hfe, 1'h0, 16'h0102},
        '{OP_INV_BIT, 8'he3, 8'h00, 8'h00, 1'h0, 8'h08, 1'h0, 16'h0102},
        '{OP_BIT_TO_C, 8'hf5, 8'h00, 8'h20, 1'h0, 8'h20, 1'h1, 16'h0102},
        '{OP_C_TO_BIT, 8'h21, 8'h00, 8'h00, 1'h1, 8'h02, 1'h1, 16'h0102},
        '{OP_AND_BIT, 8'h10, 8'h00, 8'h00, 1'h1, 8'h00, 1'h0, 16'h0102},
        '{OP_AND_NBIT, 8'h10, 8'h00, 8'h00, 1'h1, 8'h00, 1'h1, 16'h0102},
        '{OP_OR_BIT, 8'h10, 8'h00, 8'h01, 1'h0, 8'h01, 1'h1, 16'h0102},
        '{OP_OR_NBIT, 8'h10, 8'h00, 8'h01, 1'h0, 8'h01, 1'h0, 16'h0102},
        '{OP_JC, 8'h00, 8'h10, 8'h00, 1'h1, 8'h00, 1'h1, 16'h0112},
        '{OP_JC, 8'h00, 8'h10, 8'h00, 1'h0, 8'h00, 1'h0, 16'h0102},
        '{OP_JNC, 8'h00, 8'h80, 8'h00, 1'h0, 8'h00, 1'h0, 16'h0082},
        '{OP_JB, 8'h07, 8'h7f, 8'h80, 1'h0, 8'h80, 1'h0, 16'h0182},
        '{OP_JNB, 8'h07, 8'h05, 8'h80, 1'h0, 8'h80, 1'h0, 16'h0103},
        '{OP_JBC, 8'h07, 8'h00, 8'h81, 1'h0, 8'h01, 1'h0, 16'h0103},
        '{OP_JBC, 8'h07, 8'h10, 8'h01, 1'h0, 8'h01, 1'h0, 16'h0103},
        '{OP_SHORT_RELATIVE_JUMP_OP, 8'h00, 8'hfe, 8'h00, 1'h0, 8'h00, 1'h0, 16'h0100},
        '{OP_INV_BIT, 8'h92, 8'h00, 8'hff, 1'h0, 8'hfb, 1'h0, 16'h0102}};

    bbp_core bbp_core_i (.sys_clk, .nrst, .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel, .wb_dat_w, .wb_dat_r,
        .wb_ack, .port_pin, .port_out, .tmr_ovf, .timer_run, .alu_cy_we, .alu_cy, .pc_out, .busy);
    bbp_far_model #(.PERIOD(16)) bbp_far_model_i (.sys_clk, .nrst, .port_out, .ext_low, .timer_run,
        .port_pin, .tmr_ovf);

    initial
    begin
        forever #10 sys_clk = ~sys_clk;
    end

    function automatic logic [11:0] adr(input logic [7:0] a);
        return {BBP_WIN_TAG, a, 2'h0};
    endfunction : adr
    // Byte holding a bit address
    function automatic logic [7:0] bb(input logic [7:0] b);
        return b[7] ? {b[7:3], 3'h0} : {BBP_RAM_HI, b[6:3]};
    endfunction : bb
    task automatic print_verdict;
        if (bad_count == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Held until ack is sampled high
    task automatic bus(input logic we, input logic [11:0] a, input logic [31:0] d = 32'h0,
                       input logic [3:0] s = 4'hf);
        @(posedge sys_clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_dat_w <= d;
        wb_sel <= s;
        do @(posedge sys_clk); while (wb_ack !== 1'b1);
        q = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask : bus
    task automatic run(input bbp_op_t op, input logic [7:0] ba, input logic [7:0] rel);
        bus(1'b1, BBP_PC_OFS, 32'h0100);
        bus(1'b1, BBP_CMD_OFS, {11'h0, op, rel, ba});
    endtask : run

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            bad_count++;
            print_verdict();
        end
    end

    initial
    begin
        repeat (8) @(posedge sys_clk);
        nrst <= 1'b1;
        foreach (rows[i])
        begin
            bus(1'b1, adr(BBP_PSW_ADR), {24'h0, rows[i].cy, 7'h0});
            bus(1'b1, adr(bb(rows[i].ba)), {24'h0, rows[i].ini});
            run(rows[i].op, rows[i].ba, rows[i].rel);
            bus(1'b0, BBP_STAT_OFS);
            chk(32'(q[1]), 32'(rows[i].ec));
            bus(1'b0, BBP_PC_OFS);
            chk(q, {16'h0, rows[i].epc});
            bus(1'b0, adr(bb(rows[i].ba)));
            chk(q, {24'h0, rows[i].eb});
        end
        bus(1'b1, adr(8'h30), 32'h5a);
        bus(1'b0, adr(8'h30));
        chk(q, 32'h0);
        bus(1'b1, adr(8'h20), 32'hff, 4'he);
        bus(1'b0, adr(8'h20));
        chk(q, 32'h0);
        bus(1'b1, adr(BBP_PSW_ADR), 32'h0);
        alu_cy_we <= 1'b1;
        alu_cy <= 1'b1;
        @(posedge sys_clk);
        alu_cy_we <= 1'b0;
        bus(1'b0, adr(BBP_PSW_ADR));
        chk(32'(q[7]), 32'h1);
        bus(1'b1, adr(BBP_ACC_ADR), 32'h01);
        run(OP_JB, 8'hd0, 8'h04);
        bus(1'b0, BBP_PC_OFS);
        chk(q, 32'h0107);
        ext_low <= 32'h00000800;
        run(OP_JNB, 8'h93, 8'h02);
        bus(1'b0, BBP_PC_OFS);
        chk(q, 32'h0105);
        chk(32'(port_out[11]), 32'h1);
        ext_low <= 32'h0;
        run(OP_SET_BIT, 8'h8c, 8'h00);
        bus(1'b0, BBP_STAT_OFS);
        chk(32'(timer_run), 32'h1);
        repeat (40) @(posedge sys_clk);
        run(OP_CLR_BIT, 8'h8c, 8'h00);
        run(OP_JBC, 8'h8d, 8'h10);
        bus(1'b0, BBP_PC_OFS);
        chk(q, 32'h0113);
        bus(1'b0, adr(BBP_TCON_ADR));
        chk(q, 32'h0);
        run(OP_INV_BIT, 8'h80, 8'h00);
        // Let the invert land so reset has a latch to restore
        @(posedge sys_clk);
        nrst <= 1'b0;
        @(posedge sys_clk);
        chk(32'(port_out[0]), 32'h0);
        @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        chk(port_out, BBP_PORT_RST);
        chk({16'h0, pc_out}, {16'h0, BBP_PC_RST});
        print_verdict();
    end
endmodule : bbp_core_tb
`default_nettype wire

// ### bbp_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module bbp_far_model #(
    parameter int PERIOD = 16
) (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    // Pins and timers
    input  wire logic [31:0] port_out,
    input  wire logic [31:0] ext_low,
    input  wire logic [1:0]  timer_run,
    output logic      [31:0] port_pin,
    output logic      [1:0]  tmr_ovf
);
    logic [7:0] cnt_q [2];
    assign port_pin = port_out & ~ext_low;
    always_ff @(posedge sys_clk)
    begin
        for (int i = 0; i < 2; i++)
        begin
            cnt_q[i] <= (!nrst || !timer_run[i] || cnt_q[i] == 8'(PERIOD - 1)) ? 8'h00 : cnt_q[i] + 8'h01;
            tmr_ovf[i] <= nrst && timer_run[i] && cnt_q[i] == 8'(PERIOD - 1);
        end
    end
endmodule : bbp_far_model
`default_nettype wire

// ### bbp_pkg.sv
`default_nettype none
package bbp_pkg;
    // Bus map, byte addresses
    localparam logic [11:0] BBP_CMD_OFS    = 12'h000;
    localparam logic [11:0] BBP_PC_OFS     = 12'h004;
    localparam logic [11:0] BBP_STAT_OFS   = 12'h008;
    localparam logic [1:0]  BBP_WIN_TAG    = 2'h1;
    // Direct byte space
    localparam logic [3:0]  BBP_RAM_HI     = 4'h2;
    localparam logic [7:0]  BBP_TCON_ADR   = 8'h88;
    localparam logic [7:0]  BBP_PSW_ADR    = 8'hd0;
    localparam logic [7:0]  BBP_ACC_ADR    = 8'he0;
    localparam logic [7:0]  BBP_B_ADR      = 8'hf0;
    localparam logic [7:0]  BBP_PORT_ADR [4] = '{8'h80, 8'h90, 8'ha0, 8'hb0};
    // Field positions
    localparam int          BBP_CY_POS     = 7;
    localparam int          BBP_TF1_POS    = 7;
    localparam int          BBP_TR1_POS    = 6;
    localparam int          BBP_TF0_POS    = 5;
    localparam int          BBP_TR0_POS    = 4;
    // Reset values
    localparam logic [31:0] BBP_PORT_RST   = 32'hffffffff;
    localparam logic [15:0] BBP_PC_RST     = 16'h0000;
    localparam logic [7:0]  BBP_BYTE_RST   = 8'h00;
    // Instruction lengths in bytes
    localparam logic [15:0] BBP_LEN1       = 16'h0001;
    localparam logic [15:0] BBP_LEN2       = 16'h0002;
    localparam logic [15:0] BBP_LEN3       = 16'h0003;

    typedef enum logic [4:0] {
        OP_SET_C, OP_CLR_C, OP_INV_C,
        OP_SET_BIT, OP_CLR_BIT, OP_INV_BIT,
        OP_BIT_TO_C, OP_C_TO_BIT,
        OP_AND_BIT, OP_AND_NBIT, OP_OR_BIT, OP_OR_NBIT,
        OP_JC, OP_JNC, OP_JB, OP_JNB, OP_JBC, OP_SHORT_RELATIVE_JUMP_OP
    } bbp_op_t;

    typedef struct packed {
        bbp_op_t    op;
        logic [7:0] rel;
        logic [7:0] bit_adr;
    } bbp_cmd_t;

    typedef enum {ST_IDLE, ST_CYC1, ST_CYC2} bbp_state_t;
endpackage : bbp_pkg
`default_nettype wire
